// ### logic/pic_top.sv
// Prioritized interrupt controller: posted flags, masks, priority pick and dispatch sequencer.
// Assumes a CPU on clk that flags instruction ends, returns, and takes the pushes and PC load.
`timescale 1ns/1ps
`default_nettype none
module pic_top (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata_q,
  // Interrupt sources
  input  wire logic [25:0] src_event,
  input  wire logic [2:0]  gpio_pin,
  // CPU side
  input  wire logic        instr_done,
  input  wire logic [15:0] cpu_program_counter,
  input  wire logic        return_from_interrupt,
  input  wire logic [7:0]  return_flags,
  output logic             stack_push_q,
  output logic      [7:0]  stack_data_q,
  output logic             pc_load_q,
  output logic      [15:0] pc_load_val_q,
  output logic      [7:0]  vector_q,
  output logic             dispatch_busy_q,
  output logic      [7:0]  flags_q,
  output logic             global_int_enable_q
);

  logic                    rst_meta_q;
  logic                    rst_sync_n;
  logic [23:0]             posted_q;
  logic [23:0]             posted_d;
  logic [23:0]             mask_q;
  logic                    software_post_enable_q;
  pic_pkg::pic_state_t     state_q;
  logic [3:0]              step_q;
  logic [4:0]              taken_q;
  logic [2:0]              gpio_rise;
  logic [25:0]             evt_prio;
  logic [23:0]             hw_set;
  logic [23:0]             sw_set;
  logic [23:0]             clr_bits;
  logic [23:0]             take_bits;
  logic [23:0]             wr_sel;
  logic                    start;
  logic [7:0]              win_vec;

  pic_sel_if sel ();

  // Reset release through two flops; assertion is immediate, release is clean
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_q <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_n <= rst_meta_q;
    end
  end

  pic_edge_post u_edge (
    .clk   (clk),
    .rst_n (rst_sync_n),
    .pin   (gpio_pin),
    .rise  (gpio_rise)
  );

  pic_prio_enc u_enc (
    .clk   (clk),
    .rst_n (rst_sync_n),
    .sel   (sel)
  );

  // Port sources ignore the level inputs and take only synchronised edges
  always_comb begin
    evt_prio = src_event;
    for (int k = 0; k < pic_pkg::PIC_NUM_GPIO; k++) begin
      evt_prio[pic_pkg::PIC_GPIO_PRIO[k]] = gpio_rise[k]; // R7
    end
  end

  // Which clear register a write hits, spread to its eight bits
  always_comb begin
    wr_sel = '0;
    if (reg_wr) begin
      case (reg_addr)
        pic_pkg::PIC_ADDR_CLR0: wr_sel[7:0]   = 8'hff;
        pic_pkg::PIC_ADDR_CLR1: wr_sel[15:8]  = 8'hff;
        pic_pkg::PIC_ADDR_CLR2: wr_sel[23:16] = 8'hff;
        default:                wr_sel        = '0;
      endcase
    end
  end

  // Per-bit set and clear terms; slots without a source never see a set
  genvar b;
  for (b = 0; b < pic_pkg::PIC_NUM_BITS; b++) begin : g_bit
    localparam logic [4:0] P = pic_pkg::PIC_BIT_PRIO[b];
    localparam logic       V = pic_pkg::PIC_VALID_BITS[b];
    assign hw_set[b]    = V && (P != 5'h00) && evt_prio[P]; // R2 R21
    assign sw_set[b]    = V && wr_sel[b] && reg_wdata[b % 8] && software_post_enable_q; // R18 R20
    assign clr_bits[b]  = wr_sel[b] && !reg_wdata[b % 8]; // R17 R20
    assign take_bits[b] = start && V && (P == sel.win); // R2
  end

  // Posted flags: a new post in the clearing cycle wins over the clear
  assign posted_d = ((posted_q & ~clr_bits & ~take_bits) | hw_set | sw_set)
                    & pic_pkg::PIC_VALID_BITS; // R2 R5 R21

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      posted_q <= pic_pkg::PIC_BITS_RST; // R19
    end else begin
      posted_q <= posted_d;
    end
  end

  // Mask registers; masking only gates the encoder, posting carries on
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      mask_q                 <= pic_pkg::PIC_BITS_RST;
      software_post_enable_q <= 1'b0;
    end else if (reg_wr) begin
      case (reg_addr)
        pic_pkg::PIC_ADDR_MSK0: mask_q[7:0]   <= reg_wdata & pic_pkg::PIC_VALID_BITS[7:0];
        pic_pkg::PIC_ADDR_MSK1: mask_q[15:8]  <= reg_wdata & pic_pkg::PIC_VALID_BITS[15:8];
        pic_pkg::PIC_ADDR_MSK2: mask_q[23:16] <= reg_wdata & pic_pkg::PIC_VALID_BITS[23:16];
        pic_pkg::PIC_ADDR_MSK3: software_post_enable_q <= reg_wdata[pic_pkg::PIC_SWPE_BIT];
        default:                mask_q <= mask_q;
      endcase
    end
  end

  // Pending requests per priority feed the encoder
  always_comb begin
    sel.req = '0;
    for (int i = 0; i < pic_pkg::PIC_NUM_BITS; i++) begin
      if (posted_q[i] && mask_q[i] && pic_pkg::PIC_BIT_PRIO[i] != 5'h00) begin
        sel.req[pic_pkg::PIC_BIT_PRIO[i]] = 1'b1; // R3 R5 R21
      end
    end
  end

  assign win_vec = 8'(sel.win) << pic_pkg::PIC_VEC_SHIFT; // R1

  // Any path that makes a request pending, or raises global enable, shows up here at once
  assign start = (state_q == pic_pkg::PIC_IDLE) && sel.hit
                 && flags_q[pic_pkg::PIC_GIE_BIT] && instr_done; // R4 R6 R8 R14

  // Dispatch sequencer; fixed length keeps the handler latency predictable
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state_q         <= pic_pkg::PIC_IDLE;
      step_q          <= 4'h0;
      taken_q         <= 5'h00;
      dispatch_busy_q <= 1'b0;
    end else begin
      case (state_q)
        pic_pkg::PIC_IDLE: begin
          if (start) begin
            state_q         <= pic_pkg::PIC_DISP;
            step_q          <= 4'h0;
            taken_q         <= sel.win;
            dispatch_busy_q <= 1'b1;
          end
        end
        pic_pkg::PIC_DISP: begin
          step_q <= step_q + 4'h1;
          if (step_q == pic_pkg::PIC_STEP_LAST) begin
            state_q         <= pic_pkg::PIC_IDLE; // R9 R15
            dispatch_busy_q <= 1'b0;
          end
        end
        default: begin
          state_q         <= pic_pkg::PIC_IDLE;
          dispatch_busy_q <= 1'b0;
        end
      endcase
    end
  end

  // Stack pushes: PC high, PC low, then flags, one per cycle
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      stack_push_q <= 1'b0;
      stack_data_q <= pic_pkg::PIC_REG_RST;
    end else if (start) begin
      stack_push_q <= 1'b1;
      stack_data_q <= cpu_program_counter[15:8]; // R9
    end else if (state_q == pic_pkg::PIC_DISP && step_q == pic_pkg::PIC_STEP_PCL) begin
      stack_push_q <= 1'b1;
      stack_data_q <= cpu_program_counter[7:0]; // R9
    end else if (state_q == pic_pkg::PIC_DISP && step_q == pic_pkg::PIC_STEP_FLAGS) begin
      stack_push_q <= 1'b1;
      stack_data_q <= flags_q; // R9
    end else begin
      stack_push_q <= 1'b0;
    end
  end

  // PC load at the end of dispatch: high byte zero, low byte the taken vector
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      pc_load_q     <= 1'b0;
      pc_load_val_q <= 16'h0000;
    end else if (state_q == pic_pkg::PIC_DISP && step_q == pic_pkg::PIC_STEP_LOAD) begin
      pc_load_q     <= 1'b1;
      pc_load_val_q <= {8'h00, 8'(taken_q) << pic_pkg::PIC_VEC_SHIFT}; // R11
    end else begin
      pc_load_q     <= 1'b0;
    end
  end

  // Flag register: dispatch owns it while busy so the clear cannot be overwritten
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      flags_q <= pic_pkg::PIC_REG_RST;
    end else if (state_q == pic_pkg::PIC_DISP) begin
      if (step_q == pic_pkg::PIC_STEP_CLRF) begin
        flags_q <= pic_pkg::PIC_REG_RST; // R10
      end
    end else if (return_from_interrupt) begin
      flags_q <= return_flags; // R13 R14
    end else if (reg_wr && reg_addr == pic_pkg::PIC_ADDR_FLAGS) begin
      flags_q <= reg_wdata; // R12
    end
  end

  // Mirrors for the CPU: enable level and the current winning vector
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      global_int_enable_q <= 1'b0;
      vector_q            <= pic_pkg::PIC_REG_RST;
    end else begin
      global_int_enable_q <= flags_q[pic_pkg::PIC_GIE_BIT];
      vector_q            <= win_vec; // R1
    end
  end

  // Read port; reads have no side effects, unmapped addresses read zero
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      reg_rdata_q <= pic_pkg::PIC_REG_RST;
    end else if (reg_rd) begin
      case (reg_addr)
        pic_pkg::PIC_ADDR_CLR0:  reg_rdata_q <= posted_q[7:0]; // R16 R19
        pic_pkg::PIC_ADDR_CLR1:  reg_rdata_q <= posted_q[15:8]; // R16
        pic_pkg::PIC_ADDR_CLR2:  reg_rdata_q <= posted_q[23:16]; // R16
        pic_pkg::PIC_ADDR_MSK0:  reg_rdata_q <= mask_q[7:0];
        pic_pkg::PIC_ADDR_MSK1:  reg_rdata_q <= mask_q[15:8];
        pic_pkg::PIC_ADDR_MSK2:  reg_rdata_q <= mask_q[23:16];
        pic_pkg::PIC_ADDR_MSK3:  reg_rdata_q <= {software_post_enable_q, 7'h00};
        pic_pkg::PIC_ADDR_FLAGS: reg_rdata_q <= flags_q;
        default:                 reg_rdata_q <= 8'h00;
      endcase
    end else begin
      reg_rdata_q <= 8'h00;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_sync_n);

  take_needs_gie_a: assert property ($rose(dispatch_busy_q) |-> $past(flags_q[pic_pkg::PIC_GIE_BIT]) // R4
    && $past(sel.hit) && $past(instr_done))
    else $error("Dispatch began without global enable or pending request");

  disp_length_a: assert property (start |-> ##13 pc_load_q ##1 !dispatch_busy_q) // R9
    else $error("Dispatch did not load the PC after thirteen cycles");

  push_order_a: assert property (start |=> stack_push_q ##1 stack_push_q ##1 stack_push_q ##1 !stack_push_q) // R9
    else $error("Dispatch did not push exactly three bytes");

  push_pch_a: assert property (start |=> stack_data_q == $past(cpu_program_counter[15:8])) // R9
    else $error("First push was not the PC high byte");

  flag_clear_a: assert property (start |-> ##4 flags_q == 8'h00) // R10
    else $error("Flags not cleared after the pushes");

  pc_vector_a: assert property (start |-> ##13 pc_load_val_q == {8'h00, $past(win_vec, 13)}) // R11
    else $error("Loaded PC is not zero high byte with the taken vector");

  return_from_interrupt_restore_a: assert property (return_from_interrupt && state_q == pic_pkg::PIC_IDLE
    |=> flags_q == $past(return_flags)) // R13
    else $error("Return did not restore the flag register");

  post_sticks_a: assert property (|hw_set |=> (posted_q & $past(hw_set)) == $past(hw_set)) // R2
    else $error("Source event failed to post regardless of mask");

  sw_post_a: assert property (reg_wr && reg_addr == pic_pkg::PIC_ADDR_CLR0 && reg_wdata == 8'hff
    && software_post_enable_q |=> posted_q[7:0] == 8'hff) // R18
    else $error("Software post with enable set did not post");

  sw_blocked_a: assert property (reg_wr && reg_addr == pic_pkg::PIC_ADDR_CLR0 && !software_post_enable_q
    && hw_set[7:0] == 8'h00 && posted_q[7:0] == 8'h00 && !start |=> posted_q[7:0] == 8'h00) // R20
    else $error("Writing ones posted while software post was disabled");

  clr_zero_a: assert property (reg_wr && reg_addr == pic_pkg::PIC_ADDR_CLR1 && reg_wdata == 8'h00
    && hw_set[15:8] == 8'h00 |=> posted_q[15:8] == 8'h00) // R17
    else $error("Writing zero did not clear posted flags");

  rd_posted_a: assert property (reg_rd && reg_addr == pic_pkg::PIC_ADDR_CLR0
    |=> reg_rdata_q == $past(posted_q[7:0])) // R16
    else $error("Clear register read does not show posted flags");

  reserved_quiet_a: assert property ((posted_q & ~pic_pkg::PIC_VALID_BITS) == 24'h0
    && !sel.req[0] && !sel.req[15] && !sel.req[21]) // R21
    else $error("Reserved slot posted or became pending");

  mask_keeps_a: assert property (reg_wr && reg_addr == pic_pkg::PIC_ADDR_MSK0 && !start // R5
    |=> (posted_q & $past(posted_q)) == $past(posted_q))
    else $error("Mask write cleared a posted flag");

  taken_posted_a: assert property (start |-> (take_bits & posted_q & mask_q) != 24'h000000) // R3
    else $error("Dispatched source was not posted and unmasked");

  no_pend_quiet_a: assert property ((posted_q & mask_q) == 24'h000000 |-> !sel.hit) // R3
    else $error("Encoder saw a request with nothing pending");

  rd_idle_zero_a: assert property (!reg_rd |=> reg_rdata_q == 8'h00) // R16
    else $error("Read data stood longer than one cycle");

  gie_rise_take_a: assert property ($rose(flags_q[pic_pkg::PIC_GIE_BIT]) && sel.hit && instr_done // R6
    && state_q == pic_pkg::PIC_IDLE |=> dispatch_busy_q)
    else $error("Global enable rising with a pending request did not dispatch");

  busy_holds_a: assert property (dispatch_busy_q && !pc_load_q |=> dispatch_busy_q) // R9
    else $error("Dispatch ended before the PC load");

  load_aligned_a: assert property (pc_load_q |-> pc_load_val_q[15:8] == 8'h00 // R11
    && pc_load_val_q[1:0] == 2'h0)
    else $error("Loaded PC has a nonzero high byte or an unaligned vector");

endmodule
`default_nettype wire

// ### logic/pic_pkg.sv
// Constants, register map and source table of the prioritized interrupt controller.
// Assumes an 8-bit register port and a CPU core that runs on the same clock.
//
// Operation
// R1: Sources hold fixed priorities 0 to 25; vector is four times priority; lowest wins.
// R2: An interrupt condition sets the posted flag until taken or cleared.
// R3: Posted flags become pending only while their mask bit is set.
// R4: Encoder picks highest pending request; taken only while global enable is set.
// R5: Clearing a mask bit neither clears posted flags nor stops posting.
// R6: Activity follows condition, mask update, or global enable rising with pending requests.
// R7: General-purpose port sources post on edges, not levels.
// R8: Dispatch starts only once the current instruction has finished.
// R9: Dispatch lasts 13 cycles, pushing PC high, PC low, then flags.
// R10: After the pushes the flag register clears, dropping global enable.
// R11: PC high byte loads zero; PC low byte loads the selected vector.
// R12: Handlers may nest by setting global enable, minding stack depth.
// R13: Return restores PC and flags, which re-enables interrupts.
// R14: Pending requests after a return are dispatched before the next instruction.
// R15: Latency is remaining instruction cycles plus 13 dispatch plus 7 jump cycles.
// R16: Reading a clear register shows 1 for every posted flag.
// R17: Writing 0 to a clear register bit clears that posted flag.
// R18: Writing 1 posts the source only while software post enable is set.
// R19: Clear register 0 maps power-on, ext0, tx, rx, port0, ext1, sleep, port1.
// R20: With software post enable clear, ones have no effect and zeros clear.
// R21: Reserved priority slots never post, never pend, never get selected.
package pic_pkg;

  localparam int          PIC_NUM_PRIO   = 26;
  localparam int          PIC_NUM_BITS   = 24;
  localparam int          PIC_PRIO_W     = 5;
  localparam int          PIC_NUM_GPIO   = 3;
  localparam int          PIC_VEC_SHIFT  = 2;   // Vector is four times priority

  // Register offsets
  localparam logic [7:0]  PIC_ADDR_CLR0  = 8'hda;
  localparam logic [7:0]  PIC_ADDR_CLR1  = 8'hdb;
  localparam logic [7:0]  PIC_ADDR_CLR2  = 8'hdc;
  localparam logic [7:0]  PIC_ADDR_MSK3  = 8'hde;
  localparam logic [7:0]  PIC_ADDR_MSK2  = 8'hdf;
  localparam logic [7:0]  PIC_ADDR_MSK0  = 8'he0;
  localparam logic [7:0]  PIC_ADDR_MSK1  = 8'he1;
  localparam logic [7:0]  PIC_ADDR_FLAGS = 8'hf7;

  // Field positions and reset values
  localparam int          PIC_SWPE_BIT   = 7;   // Software post enable in mask register 3
  localparam int          PIC_GIE_BIT    = 0;   // Global enable inside the flag register
  localparam logic [7:0]  PIC_REG_RST    = 8'h00;
  localparam logic [23:0] PIC_BITS_RST   = 24'h000000;
  localparam logic [23:0] PIC_VALID_BITS = 24'h167fff; // Bits that own a real source

  // Priority owned by each clear/mask bit, index = register * 8 + bit; 0 means none
  localparam logic [4:0]  PIC_BIT_PRIO [PIC_NUM_BITS] = '{
    5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h07, 5'h19, 5'h06,
    5'h08, 5'h09, 5'h0a, 5'h0b, 5'h0c, 5'h0d, 5'h0e, 5'h00,
    5'h00, 5'h11, 5'h12, 5'h00, 5'h14, 5'h00, 5'h00, 5'h00};

  // Edge-posted port sources: port 0, port 1, port 2
  localparam logic [4:0]  PIC_GPIO_PRIO [PIC_NUM_GPIO] = '{5'h05, 5'h06, 5'h14};

  // Dispatch sequence, counted in steps after the start edge
  localparam int          PIC_DISP_CYCLES  = 13;
  localparam logic [3:0]  PIC_STEP_PCL     = 4'h0;
  localparam logic [3:0]  PIC_STEP_FLAGS   = 4'h1;
  localparam logic [3:0]  PIC_STEP_CLRF    = 4'h2;
  localparam logic [3:0]  PIC_STEP_LOAD    = 4'(PIC_DISP_CYCLES - 2);
  localparam logic [3:0]  PIC_STEP_LAST    = 4'(PIC_DISP_CYCLES - 1);

  typedef enum logic {PIC_IDLE, PIC_DISP} pic_state_t;

endpackage

// ### logic/pic_sel_if.sv
// Bundle between the controller core and its priority encoder.
// Assumes both ends sit on the same clock; the bundle is purely combinational.
`timescale 1ns/1ps
`default_nettype none
interface pic_sel_if;
  logic [pic_pkg::PIC_NUM_PRIO-1:0] req;
  logic                             hit;
  logic [pic_pkg::PIC_PRIO_W-1:0]   win;
  modport enc (input req, output hit, output win);
  modport ctl (output req, input hit, input win);
endinterface
`default_nettype wire

// ### logic/pic_prio_enc.sv
// Fixed-priority encoder: lowest priority number among pending requests wins.
// Assumes the request vector is already gated by the mask registers.
`timescale 1ns/1ps
`default_nettype none
module pic_prio_enc (
  // Clock and reset, for the checks only
  input wire logic clk,
  input wire logic rst_n,
  // Request and winner
  pic_sel_if.enc   sel
);

  // Scan from the top so the lowest set index is left standing
  always_comb begin
    sel.win = '0;
    for (int i = pic_pkg::PIC_NUM_PRIO - 1; i >= 0; i--) begin
      if (sel.req[i]) begin
        sel.win = pic_pkg::PIC_PRIO_W'(i); // R1
      end
    end
    sel.hit = |sel.req; // R4
  end

  lowest_wins_a: assert property (@(posedge clk) disable iff (!rst_n) // R1
    sel.hit |-> sel.req[sel.win] && ((sel.req & ((26'h1 << sel.win) - 26'h1)) == 26'h0))
    else $error("Encoder did not select the lowest pending priority");

endmodule
`default_nettype wire

// ### logic/pic_edge_post.sv
// Port pin edge detector: synchronises pins and turns rising edges into one-cycle posts.
// Assumes pins are asynchronous to clk; a pin must hold each level for two clocks.
`timescale 1ns/1ps
`default_nettype none
module pic_edge_post (
  // Clock and reset
  input  wire logic                           clk,
  input  wire logic                           rst_n,
  // Pins and posts
  input  wire logic [pic_pkg::PIC_NUM_GPIO-1:0] pin,
  output logic      [pic_pkg::PIC_NUM_GPIO-1:0] rise
);

  logic [pic_pkg::PIC_NUM_GPIO-1:0] meta_q;
  logic [pic_pkg::PIC_NUM_GPIO-1:0] sync_q;
  logic [pic_pkg::PIC_NUM_GPIO-1:0] last_q;

  // Two flops per pin, then a history flop for the edge compare
  genvar g;
  for (g = 0; g < pic_pkg::PIC_NUM_GPIO; g++) begin : g_pin
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        meta_q[g] <= 1'b0;
        sync_q[g] <= 1'b0;
        last_q[g] <= 1'b0;
      end else begin
        meta_q[g] <= pin[g];
        sync_q[g] <= meta_q[g];
        last_q[g] <= sync_q[g];
      end
    end
    assign rise[g] = sync_q[g] & ~last_q[g]; // R7
  end

  edge_pulse_a: assert property (@(posedge clk) disable iff (!rst_n) // R7
    rise[0] |=> !rise[0])
    else $error("Port post lasted more than one cycle on a steady level");

endmodule
`default_nettype wire

// ### verification/pic_cpu_model.sv
// CPU core stand-in: instruction ends, stack of one frame, return.
// Assumes pic_top on the same clock; the bench commands returns and slow mode.
`timescale 1ns/1ps
`default_nettype none
module pic_cpu_model (
  // Clock, reset and commands
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        slow,
  input  wire logic        ret_req,
  // From the controller
  input  wire logic        stack_push_q,
  input  wire logic [7:0]  stack_data_q,
  input  wire logic        pc_load_q,
  input  wire logic [15:0] pc_load_val_q,
  // To the controller
  output logic             instr_done,
  output logic      [15:0] pc_q,
  output logic             ret_q,
  output logic      [7:0]  ret_flags
);
  logic [23:0] stk_q;
  logic [1:0]  cnt_q;
  // Slow mode ends an instruction one cycle in four
  assign instr_done = slow ? (cnt_q == 2'h3) : 1'b1;
  // Popped flags valid only with the return pulse, inverted otherwise
  assign ret_flags = ret_q ? stk_q[7:0] : ~stk_q[7:0];
  // Stack, program counter and return pulse
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 2'h0;
      stk_q <= 24'h000000;
      ret_q <= 1'b0;
      pc_q  <= 16'ha55a;
    end else begin
      cnt_q <= cnt_q + 2'h1;
      ret_q <= ret_req;
      if (stack_push_q) begin
        stk_q <= {stk_q[15:0], stack_data_q};
      end
      if (pc_load_q) begin
        pc_q <= pc_load_val_q;
      end else if (ret_req) begin
        pc_q <= stk_q[23:8];
      end
    end
  end
endmodule
`default_nettype wire

// ### verification/tb_top.sv
// Self-checking bench: registers, posting, masks, edge sources and dispatch.
// Assumes pic_top and pic_cpu_model; stimulus by non-blocking assignment on rising edges.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [25:0] src_event = '0;
  logic [2:0]  gpio_pin = 3'h0;
  logic        slow = 1'b0;
  logic        ret_req = 1'b0;
  logic [7:0]  reg_rdata_q, stack_data_q, vector_q, flags_q, ret_flags;
  logic        stack_push_q, pc_load_q, dispatch_busy_q, global_int_enable_q, instr_done, ret_q;
  logic [15:0] pc_load_val_q, pc_q;
  int          miscompares = 0;
  int          comparisons = 0;

  always #5 clk = ~clk;

  pic_top pic_top_i (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .src_event(src_event),
    .gpio_pin(gpio_pin), .instr_done(instr_done), .cpu_program_counter(pc_q),
    .return_from_interrupt(ret_q), .return_flags(ret_flags), .stack_push_q(stack_push_q),
    .stack_data_q(stack_data_q), .pc_load_q(pc_load_q), .pc_load_val_q(pc_load_val_q),
    .vector_q(vector_q), .dispatch_busy_q(dispatch_busy_q), .flags_q(flags_q),
    .global_int_enable_q(global_int_enable_q));

  pic_cpu_model pic_cpu_model_i (.clk(clk), .rst_n(rst_n), .slow(slow), .ret_req(ret_req),
    .stack_push_q(stack_push_q), .stack_data_q(stack_data_q), .pc_load_q(pc_load_q),
    .pc_load_val_q(pc_load_val_q), .instr_done(instr_done), .pc_q(pc_q), .ret_q(ret_q),
    .ret_flags(ret_flags));

  task automatic close_out();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk("rdata", {8'h00, e}, {8'h00, reg_rdata_q});
  endtask

  task automatic ev(input logic [25:0] v);
    @(posedge clk);
    src_event <= v;
    @(posedge clk);
    src_event <= '0;
  endtask

  task automatic ret(input logic s);
    @(posedge clk);
    ret_req <= 1'b1;
    slow    <= s;
    @(posedge clk);
    ret_req <= 1'b0;
  endtask

  // Follows one dispatch: three pushes, flags cleared, PC load, busy length
  task automatic disp(input logic [7:0] v);
    int n;
    int k;
    n = 0;
    k = 0;
    while (dispatch_busy_q !== 1'b1 && n < 60) begin
      tick(1);
      n++;
    end
    if (n == 60) begin
      miscompares++;
      close_out();
    end
    chk("push_hi", 16'h01a5, {7'h00, stack_push_q, stack_data_q});
    chk("vector", {8'h00, v}, {8'h00, vector_q});
    tick(1);
    chk("push_lo", 16'h015a, {7'h00, stack_push_q, stack_data_q});
    tick(1);
    chk("push_flags", 16'h0101, {7'h00, stack_push_q, stack_data_q});
    tick(1);
    chk("flags_cleared", 16'h0000, {7'h00, stack_push_q, flags_q});
    n = 3;
    while (dispatch_busy_q === 1'b1 && n < 30) begin
      n++;
      if (pc_load_q === 1'b1) begin
        k = n;
        chk("pc_load", {8'h00, v}, pc_load_val_q);
      end
      tick(1);
    end
    chk("load_cycle", 16'h000d, 16'(k));
    chk("busy_len", 16'h000d, 16'(n));
  endtask

  task automatic t_regs();
    logic [7:0] a [3];
    logic [7:0] m [3];
    logic [7:0] p [3];
    a = '{8'hda, 8'hdb, 8'hdc};
    m = '{8'hff, 8'h7f, 8'h16};
    p = '{8'h6f, 8'h7f, 8'h06};
    ev(26'h1e98001);
    ev(26'h2067f9e);
    for (int i = 0; i < 3; i++) begin
      rd_chk(a[i], p[i]);
      wr(a[i], 8'h00);
      rd_chk(a[i], 8'h00);
      wr(a[i], 8'hff);
      rd_chk(a[i], 8'h00);
      wr(8'hde, 8'h80);
      wr(a[i], 8'hff);
      rd_chk(a[i], m[i]);
      wr(a[i], 8'h00);
      rd_chk(a[i], 8'h00);
      wr(8'hde, 8'h00);
    end
  endtask

  task automatic t_disp();
    wr(8'hf7, 8'h01);
    ev(26'h0000088);
    tick(10);
    chk("masked_idle", {15'h0000, dispatch_busy_q}, 16'h0000);
    chk("gie", {15'h0000, global_int_enable_q}, 16'h0001);
    rd_chk(8'hda, 8'h24);
    wr(8'he0, 8'hff);
    disp(8'h0c);
    rd_chk(8'hda, 8'h20);
    tick(10);
    chk("held_off", {15'h0000, dispatch_busy_q}, 16'h0000);
    ret(1'b1);
    disp(8'h1c);
    rd_chk(8'hda, 8'h00);
    ret(1'b0);
    tick(4);
    chk("flags_back", {8'h00, flags_q}, 16'h0001);
    wr(8'he0, 8'h00);
  endtask

  // Port sources post on the rising edge only
  task automatic t_gpio();
    @(posedge clk);
    gpio_pin <= 3'h7;
    tick(8);
    rd_chk(8'hda, 8'h90);
    rd_chk(8'hdc, 8'h10);
    wr(8'hda, 8'h00);
    wr(8'hdc, 8'h00);
    tick(8);
    rd_chk(8'hda, 8'h00);
    @(posedge clk);
    gpio_pin <= 3'h0;
    tick(8);
    rd_chk(8'hda, 8'h00);
    rd_chk(8'hdc, 8'h00);
  endtask

  initial begin
    logic [7:0] r [9];
    r = '{8'hda, 8'hdb, 8'hdc, 8'hde, 8'hdf, 8'he0, 8'he1, 8'hf7, 8'h00};
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    for (int i = 0; i < 9; i++) begin
      rd_chk(r[i], 8'h00);
    end
    t_regs();
    t_disp();
    t_gpio();
    close_out();
  end
endmodule
`default_nettype wire
